// ===== icgsl_consts.vh
// Constants for the internal clock settle, trim and low-power controller.
// Shared by the core, its checker and its bench.
`ifndef ICGSL_CONSTS_VH
`define ICGSL_CONSTS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ICGSL_ADDR_CTRL      4'h0
`define ICGSL_ADDR_MULT      4'h1
`define ICGSL_ADDR_TRIM      4'h2
`define ICGSL_ADDR_DIV       4'h3
`define ICGSL_ADDR_STAGE     4'h4
`define ICGSL_ADDR_ERR       4'h5

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define ICGSL_CTRL_MIE       7
`define ICGSL_CTRL_MFLAG     6
`define ICGSL_CTRL_MON       5
`define ICGSL_CTRL_SRC       4
`define ICGSL_CTRL_ION       3
`define ICGSL_CTRL_ISTB      2
`define ICGSL_CTRL_EON       1
`define ICGSL_CTRL_ESTB      0

// ----------------------------------------------------------------------------
// Reset values and divider maximum
// ----------------------------------------------------------------------------
`define ICGSL_RST_MULT       7'h15
`define ICGSL_RST_TRIM       8'h80
`define ICGSL_RST_DIV        4'h0
`define ICGSL_RST_STAGE      8'h00
`define ICGSL_DIV_MAX        4'h9

// ----------------------------------------------------------------------------
// Capacitor and loop figures
// ----------------------------------------------------------------------------
`define ICGSL_CAP_TOTAL      10'h27f
`define ICGSL_CAP_FIXED      10'h180
`define ICGSL_BASE_PER_STEP  3'h4
`define ICGSL_BUS_DIV        3'h4
`define ICGSL_FINE_MAX       7'h58
`define ICGSL_COARSE_STEP    8'h20
`define ICGSL_FINE_STEP      8'h01
// Fifteen percent, expressed in the error input's units of 1/1024
`define ICGSL_ERR_15PCT      11'h099

`endif

// ===== icgsl_core.v
// Loop control of the internal clock generator: settle, trim, wait and stop.
// Assumes the analog comparator delivers a signed period error and that
// low_freq_base_clock and stop/wait levels arrive asynchronously.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "icgsl_consts.vh"

// Notes on behaviour
// - Reset, multiplier or trim write, or oscillator re-enable restarts correction.
// - Each correction step spans four low-frequency base clock periods.
// - Error above fifteen percent uses coarse steps, eight double or halve period.
// - Stable bit sets once the period is within fifteen percent.
// - Within fifteen percent, steps are the minimum stage size.
// - Fine mode reaches minimum error within 88 corrections.
// - Capacitor is 639 units: 384 fixed plus 255 by trim.
// - Trim resets to 128 units, capacitor 512 units.
// - Each trim unit moves frequency about 0.195 percent; more trim, lower.
// - Bus frequency is base frequency times multiplier divided by four.
// - Generator stays active in wait; its interrupt may wake the core.
// - Stop without keep option halts all and holds clock outputs low.
// - Stop with keep option runs clocks; generator interrupts do not wake.
// - Stop without keep option clears internal and external stable bits.
// - Stop without keep option clears monitor enable, its irq enable and flag.
// - Stop leaves source, generator enables, multiplier, trim, divider and stages alone.
// - Oscillator frequency is multiplier times the base clock.
module icgsl_core (
  // Clock and reset
  input  wire        clk,
  input  wire        resetn,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // Analog side
  input  wire        low_freq_base_clock,
  input  wire        err_slow,
  input  wire [10:0] err_mag,
  input  wire        ext_clock_active,
  input  wire        monitor_event,
  input  wire        keep_osc_in_stop,
  // Low-power mode
  input  wire        stop_mode,
  input  wire        wait_mode,
  // Oscillator controls
  output reg  [3:0]  osc_divider_ctrl,
  output reg  [7:0]  osc_stage_ctrl,
  output wire [9:0]  cap_units,
  output wire [6:0]  mult_factor,
  output wire        osc_run,
  // Clock outputs and wake
  output wire        reference_clock_out,
  output wire        bus_clock_out,
  output wire        timebase_clock_out,
  output wire        wake_request,
  output wire        irq_out
);

  // --------------------------------------------------------------------------
  // State and storage
  // --------------------------------------------------------------------------
  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_COARSE = 2'h1;
  localparam [1:0] ST_FINE   = 2'h2;
  localparam [1:0] ST_LOCKED = 2'h3;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [6:0]  mult_reg;
  reg  [7:0]  trim_reg;
  reg         mon_ie_reg;
  reg         mon_flag_reg;
  reg         mon_on_reg;
  reg         src_ext_reg;
  reg         int_generator_on_reg;
  reg         int_clock_stable_reg;
  reg         ext_generator_on_reg;
  reg         ext_clock_stable_reg;
  reg  [6:0]  fine_cnt_reg;
  reg  [1:0]  base_cnt_reg;
  reg  [2:0]  base_sync_reg;
  reg  [2:0]  stop_sync_reg;
  reg  [2:0]  wait_sync_reg;
  reg  [2:0]  keep_sync_reg;
  reg         base_level_reg;
  reg         stop_reg;
  reg         wait_reg;
  reg         keep_reg;
  reg         restart_reg;
  reg  [1:0]  bus_div_reg;
  reg         bus_clk_reg;
  reg         ref_clk_reg;
  wire        halted;
  wire        base_edge;
  wire        step_en;
  wire        err_big;
  wire        err_zero;
  wire        wr_ctrl;
  wire        wr_mult;
  wire        wr_trim;
  wire [11:0] stage_sum;

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      base_sync_reg  <= 3'h0;
      stop_sync_reg  <= 3'h0;
      wait_sync_reg  <= 3'h0;
      keep_sync_reg  <= 3'h0;
      base_level_reg <= 1'b0;
      stop_reg       <= 1'b0;
      wait_reg       <= 1'b0;
      keep_reg       <= 1'b0;
    end else begin
      base_sync_reg <= {base_sync_reg[1:0], low_freq_base_clock};
      stop_sync_reg <= {stop_sync_reg[1:0], stop_mode};
      wait_sync_reg <= {wait_sync_reg[1:0], wait_mode};
      keep_sync_reg <= {keep_sync_reg[1:0], keep_osc_in_stop};
      if (base_sync_reg[1] == base_sync_reg[2])
        base_level_reg <= base_sync_reg[2];
      if (stop_sync_reg[1] == stop_sync_reg[2])
        stop_reg <= stop_sync_reg[2];
      if (wait_sync_reg[1] == wait_sync_reg[2])
        wait_reg <= wait_sync_reg[2];
      if (keep_sync_reg[1] == keep_sync_reg[2])
        keep_reg <= keep_sync_reg[2];
    end
  end
  assign halted = stop_reg & ~keep_reg;
  assign base_edge = (base_sync_reg[2] == base_sync_reg[1]) & base_sync_reg[2] & ~base_level_reg;

  // --------------------------------------------------------------------------
  // Correction interval
  // --------------------------------------------------------------------------
  // four base periods
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      base_cnt_reg <= 2'h0;
    end else if (halted || restart_reg) begin
      base_cnt_reg <= 2'h0;
    end else if (base_edge) begin
      base_cnt_reg <= base_cnt_reg + 2'h1;
    end
  end

  assign step_en = base_edge & (base_cnt_reg == 2'h3) & ~halted & int_generator_on_reg;
  assign err_big  = (err_mag > `ICGSL_ERR_15PCT);
  assign err_zero = (err_mag == 11'h000);

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  assign wr_ctrl = reg_wr & (reg_addr == `ICGSL_ADDR_CTRL);
  assign wr_mult = reg_wr & (reg_addr == `ICGSL_ADDR_MULT);
  assign wr_trim = reg_wr & (reg_addr == `ICGSL_ADDR_TRIM);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trim_reg             <= `ICGSL_RST_TRIM;
      mult_reg             <= `ICGSL_RST_MULT;
      int_generator_on_reg <= 1'b1;
      ext_generator_on_reg <= 1'b0;
      src_ext_reg          <= 1'b0;
    end else if (wr_ctrl) begin
      int_generator_on_reg <= reg_wdata[`ICGSL_CTRL_ION] | ~reg_wdata[`ICGSL_CTRL_EON];
      ext_generator_on_reg <= reg_wdata[`ICGSL_CTRL_EON] | ~reg_wdata[`ICGSL_CTRL_ION];
      src_ext_reg          <= reg_wdata[`ICGSL_CTRL_SRC] | ~reg_wdata[`ICGSL_CTRL_ION];
    end else if (wr_mult) begin
      mult_reg <= reg_wdata[6:0];
    end else if (wr_trim) begin
      trim_reg <= reg_wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Monitor and stable bits
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mon_on_reg           <= 1'b0;
      mon_ie_reg           <= 1'b0;
      mon_flag_reg         <= 1'b0;
      ext_clock_stable_reg <= 1'b0;
    end else if (halted) begin
      mon_on_reg           <= 1'b0;
      mon_ie_reg           <= 1'b0;
      mon_flag_reg         <= 1'b0;
      ext_clock_stable_reg <= 1'b0;
    end else begin
      ext_clock_stable_reg <= ext_generator_on_reg & ext_clock_active;
      if (wr_mult || wr_trim) begin
        mon_on_reg   <= 1'b0;
        mon_ie_reg   <= 1'b0;
        mon_flag_reg <= 1'b0;
      end else if (wr_ctrl) begin
        mon_on_reg   <= reg_wdata[`ICGSL_CTRL_MON] &
                        (mon_on_reg | (int_clock_stable_reg & ext_clock_stable_reg));
        mon_ie_reg   <= reg_wdata[`ICGSL_CTRL_MIE] & reg_wdata[`ICGSL_CTRL_MON] & mon_on_reg;
        // Set wins over a software clear arriving in the same cycle
        mon_flag_reg <= (mon_flag_reg & reg_wdata[`ICGSL_CTRL_MFLAG] &
                         reg_wdata[`ICGSL_CTRL_MON]) | (monitor_event & mon_on_reg);
      end else begin
        mon_flag_reg <= mon_flag_reg | (monitor_event & mon_on_reg);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Loop filter state machine
  // --------------------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (step_en)
          state_next = err_big ? ST_COARSE : ST_FINE;
      end
      ST_COARSE: begin
        if (step_en && !err_big)
          state_next = ST_FINE;
      end
      ST_FINE: begin
        if (step_en && err_big)
          state_next = ST_COARSE;
        else if (step_en && (err_zero || fine_cnt_reg == `ICGSL_FINE_MAX - 7'h01))
          state_next = ST_LOCKED;
      end
      ST_LOCKED: begin
        if (step_en && err_big)
          state_next = ST_COARSE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      restart_reg <= 1'b1;
    end else begin
      restart_reg <= wr_mult | wr_trim | halted | ~int_generator_on_reg;
    end
  end
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg            <= ST_IDLE;
      fine_cnt_reg         <= 7'h00;
      int_clock_stable_reg <= 1'b0;
    end else if (restart_reg) begin
      state_reg            <= ST_IDLE;
      fine_cnt_reg         <= 7'h00;
      int_clock_stable_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_next == ST_FINE && state_reg != ST_FINE)
        fine_cnt_reg <= 7'h00;
      else if (step_en && state_reg == ST_FINE)
        fine_cnt_reg <= fine_cnt_reg + 7'h01;
      if (step_en)
        int_clock_stable_reg <= ~err_big;
    end
  end

  // --------------------------------------------------------------------------
  // Divider and stage update
  // --------------------------------------------------------------------------
  // Divider and stage form one 12-bit number; stage carry moves the divider
  assign stage_sum = err_slow ?
    {osc_divider_ctrl, osc_stage_ctrl} -
      {4'h0, (err_big ? `ICGSL_COARSE_STEP : `ICGSL_FINE_STEP)} :
    {osc_divider_ctrl, osc_stage_ctrl} +
      {4'h0, (err_big ? `ICGSL_COARSE_STEP : `ICGSL_FINE_STEP)};
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_divider_ctrl <= `ICGSL_RST_DIV;
      osc_stage_ctrl   <= `ICGSL_RST_STAGE;
    end else if (step_en && !err_zero && state_reg != ST_LOCKED) begin
      if (err_slow && {osc_divider_ctrl, osc_stage_ctrl} <
          {4'h0, (err_big ? `ICGSL_COARSE_STEP : `ICGSL_FINE_STEP)}) begin
        osc_divider_ctrl <= 4'h0;
        osc_stage_ctrl   <= 8'h00;
      end else if (!err_slow && stage_sum[11:8] > `ICGSL_DIV_MAX) begin
        osc_divider_ctrl <= `ICGSL_DIV_MAX;
        osc_stage_ctrl   <= 8'hff;
      end else begin
        osc_divider_ctrl <= stage_sum[11:8];
        osc_stage_ctrl   <= stage_sum[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Clock outputs
  // --------------------------------------------------------------------------
  // bus is reference divided by four
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_div_reg <= 2'h0;
      bus_clk_reg <= 1'b0;
      ref_clk_reg <= 1'b0;
    end else if (halted) begin
      bus_div_reg <= 2'h0;
      bus_clk_reg <= 1'b0;
      ref_clk_reg <= 1'b0;
    end else begin
      ref_clk_reg <= ~ref_clk_reg;
      if (ref_clk_reg) begin
        bus_div_reg <= bus_div_reg + 2'h1;
        if (bus_div_reg[0])
          bus_clk_reg <= ~bus_clk_reg;
      end
    end
  end

  assign reference_clock_out = ref_clk_reg & ~halted;
  assign bus_clock_out       = bus_clk_reg & ~halted;
  assign timebase_clock_out  = ref_clk_reg & ~halted;
  assign cap_units   = `ICGSL_CAP_FIXED + {2'h0, trim_reg};
  assign mult_factor = mult_reg;
  assign osc_run     = int_generator_on_reg & ~halted;
  assign irq_out      = mon_ie_reg & mon_flag_reg;
  assign wake_request = irq_out & wait_reg & ~stop_reg;

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ICGSL_ADDR_CTRL:  reg_rdata <= {mon_ie_reg, mon_flag_reg, mon_on_reg, src_ext_reg,
                                         int_generator_on_reg, int_clock_stable_reg,
                                         ext_generator_on_reg, ext_clock_stable_reg};
        `ICGSL_ADDR_MULT:  reg_rdata <= {1'b0, mult_reg};
        `ICGSL_ADDR_TRIM:  reg_rdata <= trim_reg;
        `ICGSL_ADDR_DIV:   reg_rdata <= {4'h0, osc_divider_ctrl};
        `ICGSL_ADDR_STAGE: reg_rdata <= osc_stage_ctrl;
        `ICGSL_ADDR_ERR:   reg_rdata <= {err_big, err_slow, 4'h0, state_reg};
        default:           reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ===== icgsl_properties.sv
// Concurrent checks on the clock generator loop controller ports.
// Assumes binding to icgsl_core; one clock domain, reset active low.
`timescale 1ns/1ns
`default_nettype none
`include "icgsl_consts.vh"
module icgsl_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Register port
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  // Mode inputs
  input wire logic        keep_osc_in_stop,
  input wire logic        stop_mode,
  // Oscillator controls and clock outputs
  input wire logic [3:0]  osc_divider_ctrl,
  input wire logic [7:0]  osc_stage_ctrl,
  input wire logic [9:0]  cap_units,
  input wire logic [6:0]  mult_factor,
  input wire logic        reference_clock_out,
  input wire logic        bus_clock_out,
  input wire logic        timebase_clock_out,
  input wire logic        wake_request,
  input wire logic        irq_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Mode inputs pass a synchroniser, so six samples leave margin for it
  sequence s_halt;
    (stop_mode && !keep_osc_in_stop)[*6];
  endsequence
  sequence s_step;
    $changed(osc_stage_ctrl);
  endsequence
  property p_cap_range;
    cap_units >= `ICGSL_CAP_FIXED && cap_units <= `ICGSL_CAP_TOTAL;
  endproperty
  property p_cap_write;
    $changed(cap_units) |-> $past(reg_wr) && $past(reg_addr) == `ICGSL_ADDR_TRIM
      && cap_units == `ICGSL_CAP_FIXED + $past(reg_wdata);
  endproperty
  property p_mult_write;
    $changed(mult_factor) |-> $past(reg_wr) && $past(reg_addr) == `ICGSL_ADDR_MULT
      && {1'b0, mult_factor} == ($past(reg_wdata) & 8'h7f);
  endproperty
  property p_step_size;
    s_step |-> 8'(osc_stage_ctrl - $past(osc_stage_ctrl)) inside {8'h01, 8'hff, 8'h20, 8'he0};
  endproperty
  property p_step_gap;
    s_step |=> $stable(osc_stage_ctrl)[*8];
  endproperty
  property p_div_carry;
    $changed(osc_divider_ctrl) |-> $changed(osc_stage_ctrl)
      && osc_divider_ctrl <= `ICGSL_DIV_MAX;
  endproperty
  property p_halt_low;
    s_halt |-> !reference_clock_out && !bus_clock_out && !timebase_clock_out;
  endproperty
  property p_halt_hold;
    s_halt |-> $stable(osc_stage_ctrl) && $stable(osc_divider_ctrl);
  endproperty
  property p_keep_run;
    (stop_mode && keep_osc_in_stop)[*6] |-> !wake_request
      && reference_clock_out != $past(reference_clock_out)
      && timebase_clock_out != $past(timebase_clock_out);
  endproperty
  property p_wake;
    wake_request |-> irq_out;
  endproperty
  property p_bus_div;
    $rose(bus_clock_out) |-> !$past(bus_clock_out, 4);
  endproperty
  a_cap_range: assert property (p_cap_range) else $error("capacitor units out of range");
  a_cap_write: assert property (p_cap_write) else $error("capacitor not trim based");
  a_mult_write: assert property (p_mult_write) else $error("multiplier changed alone");
  a_step_size: assert property (p_step_size) else $error("bad correction size");
  a_step_gap: assert property (p_step_gap) else $error("corrections too close");
  a_div_carry: assert property (p_div_carry) else $error("divider moved without carry");
  a_halt_low: assert property (p_halt_low) else $error("clocks run while halted");
  a_halt_hold: assert property (p_halt_hold) else $error("loop moved while halted");
  a_keep_run: assert property (p_keep_run) else $error("keep mode clocks wrong");
  a_wake: assert property (p_wake) else $error("wake without interrupt");
  a_bus_div: assert property (p_bus_div) else $error("bus clock too fast");
endmodule
bind icgsl_core icgsl_checker icgsl_checker_inst (.clk, .resetn, .reg_addr, .reg_wdata,
  .reg_wr, .keep_osc_in_stop, .stop_mode, .osc_divider_ctrl, .osc_stage_ctrl, .cap_units,
  .mult_factor, .reference_clock_out, .bus_clock_out, .timebase_clock_out, .wake_request,
  .irq_out);
`default_nettype wire

// ===== icgsl_core_tb.sv
// Self-checking bench for the clock generator loop controller.
// Assumes icgsl_core and its bound checker; the base clock is made here at clk/8.
`timescale 1ns/1ns
`default_nettype none
`include "icgsl_consts.vh"
module icgsl_core_tb;
  logic        clk, resetn, reg_wr, reg_rd, low_freq_base_clock, err_slow;
  logic        ext_clock_active, monitor_event, keep_osc_in_stop, stop_mode, wait_mode;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [10:0] err_mag;
  logic [2:0]  base_cnt;
  wire  [7:0]  reg_rdata, osc_stage_ctrl;
  wire  [3:0]  osc_divider_ctrl;
  wire  [9:0]  cap_units;
  wire  [6:0]  mult_factor;
  wire         osc_run, reference_clock_out, bus_clock_out, timebase_clock_out;
  wire         wake_request, irq_out;
  int          mismatches, check_count;
  icgsl_core icgsl_core_inst (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .low_freq_base_clock, .err_slow, .err_mag, .ext_clock_active,
    .monitor_event, .keep_osc_in_stop, .stop_mode, .wait_mode, .osc_divider_ctrl,
    .osc_stage_ctrl, .cap_units, .mult_factor, .osc_run, .reference_clock_out,
    .bus_clock_out, .timebase_clock_out, .wake_request, .irq_out);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // One correction spans four base periods, 32 clk cycles here
  // Held at zero in reset so this process is the only driver of the base clock
  always @(posedge clk) begin
    base_cnt <= resetn ? base_cnt + 3'h1 : 3'h0;
    low_freq_base_clock <= resetn & base_cnt[2];
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Counts edges until the next correction lands
  task automatic step(output int n);
    logic [7:0] old;
    old = osc_stage_ctrl;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (osc_stage_ctrl === old && n < 300);
    if (n >= 300) begin
      mismatches++;
      $display("[ERR] %0t no correction step", $time);
    end
  endtask
  task automatic test_done;
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] d;
    rd(`ICGSL_ADDR_CTRL, d);
    chk(d, 10'h008);
    rd(`ICGSL_ADDR_TRIM, d);
    chk(d, 10'h080);
    chk(cap_units, 10'h200);
    chk(mult_factor, 10'h015);
    rd(4'hf, d);
    chk(d, 10'h000);
  endtask
  task automatic t_settle;
    int n;
    logic [7:0] p, d;
    logic [3:0] dv;
    step(n);
    dv = osc_divider_ctrl;
    for (int i = 0; i < 8; i++) begin
      p = osc_stage_ctrl;
      step(n);
      chk(n, 32);
      chk(8'(osc_stage_ctrl - p), 10'h020);
    end
    chk(osc_divider_ctrl, 4'(dv + 4'h1));
    rd(`ICGSL_ADDR_ERR, d);
    chk(d[7:6], 2'h2);
    rd(`ICGSL_ADDR_CTRL, d);
    chk(d[2], 1'b0);
    @(posedge clk);
    err_mag <= `ICGSL_ERR_15PCT;
    err_slow <= 1'b1;
    p = osc_stage_ctrl;
    step(n);
    chk(8'(osc_stage_ctrl - p), 10'h0ff);
    rd(`ICGSL_ADDR_CTRL, d);
    chk(d[2], 1'b1);
    rd(`ICGSL_ADDR_ERR, d);
    chk(d[7:6], 2'h1);
  endtask
  task automatic t_trim;
    logic [7:0] tv[3] = '{8'hff, 8'h00, 8'h81};
    logic [7:0] d;
    for (int i = 0; i < 3; i++) begin
      wr(`ICGSL_ADDR_TRIM, tv[i]);
      chk(cap_units, 10'h180 + tv[i]);
    end
    rd(`ICGSL_ADDR_CTRL, d);
    chk(d[2], 1'b0);
    wr(`ICGSL_ADDR_MULT, 8'h20);
    chk(mult_factor, 10'h020);
  endtask
  task automatic t_lowpower;
    int n;
    logic [7:0] d, st;
    logic [3:0] dv;
    logic r;
    step(n);
    wr(`ICGSL_ADDR_CTRL, 8'h0a);
    wr(`ICGSL_ADDR_CTRL, 8'h2a);
    wr(`ICGSL_ADDR_CTRL, 8'haa);
    @(posedge clk);
    monitor_event <= 1'b1;
    @(posedge clk);
    monitor_event <= 1'b0;
    rd(`ICGSL_ADDR_CTRL, d);
    chk(d, 10'h0ef);
    @(posedge clk);
    wait_mode <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk(wake_request, 1'b1);
    @(posedge clk);
    stop_mode <= 1'b1;
    keep_osc_in_stop <= 1'b1;
    repeat (7) @(posedge clk);
    #1 chk(wake_request, 1'b0);
    chk(osc_run, 1'b1);
    r = reference_clock_out;
    @(posedge clk);
    #1 chk(reference_clock_out, !r);
    @(posedge clk);
    keep_osc_in_stop <= 1'b0;
    repeat (7) @(posedge clk);
    #1 chk({reference_clock_out, bus_clock_out, timebase_clock_out}, 10'h000);
    chk(osc_run, 1'b0);
    st = osc_stage_ctrl;
    dv = osc_divider_ctrl;
    rd(`ICGSL_ADDR_CTRL, d);
    chk(d, 10'h00a);
    rd(`ICGSL_ADDR_TRIM, d);
    chk(d, 10'h081);
    repeat (40) @(posedge clk);
    #1 chk(osc_divider_ctrl, dv);
    chk(osc_stage_ctrl, st);
    @(posedge clk);
    stop_mode <= 1'b0;
    wait_mode <= 1'b0;
  endtask
  initial begin
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {err_slow, monitor_event, keep_osc_in_stop} = '0;
    {stop_mode, wait_mode} = '0;
    ext_clock_active = 1'b1;
    err_mag = 11'h200;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_settle();
    t_trim();
    t_lowpower();
    test_done();
  end
  initial begin
    #60000;
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
